/* design/rtp_pkg.sv */
// Constants shared by the real-time pattern output port.
// Assumes a 32-bit Avalon-MM slave port addressed by byte.
package rtp_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;
    localparam int NIB_W = 4;

    // Byte offsets of the registers.
    localparam logic [ADDR_W-1:0] OFS_BUF_UPPER = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_BUF_LOWER = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_PIN_SELECT = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_PORT_CTRL = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_MOD_CTRL = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_PORT_LATCH = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_PIN_DIR = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_RT_LATCH = 5'h1c;

    // Field positions in the port control register.
    localparam int PC_BYTE_BIT = 0;
    localparam int PC_EXTR_BIT = 1;
    localparam int PC_OE_BIT = 2;
    localparam int PC_W = 3;

    // Field positions in the modulation control register.
    localparam int MC_DCEN_BIT = 0;
    localparam int MC_INV_BIT = 1;
    localparam int MC_PWML_BIT = 2;
    localparam int MC_PWMH_BIT = 3;
    localparam int MC_W = 4;

    // Values after reset.
    localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
    localparam logic [PORT_W-1:0] RST_SELECT = 8'h00;
    localparam logic [PORT_W-1:0] RST_LATCH = 8'h00;
    localparam logic [PORT_W-1:0] RST_DIR = 8'hff;
    localparam logic [PC_W-1:0] RST_PC = 3'h0;
    localparam logic [MC_W-1:0] RST_MC = 4'h0;

    // Number of synchroniser stages on pin inputs.
    localparam int SYNC_STAGES = 2;

endpackage

/* design/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs change independently of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import rtp_pkg::*;

    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("pin_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* design/pin_drive.sv */
// Per-pin output selection for the real-time port.
// Assumes all control inputs are on sys_clk; outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module pin_drive #(
    parameter int PINS = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [PINS-1:0] pin_direction_bit,
    input wire logic [PINS-1:0] pin_output_latch,
    input wire logic [PINS-1:0] rt_latch,
    input wire logic [PINS-1:0] per_pin_rt_select,
    input wire logic [PINS-1:0] pwm_enable,
    input wire logic rt_output_enable,
    input wire logic modulation_dc_enable,
    input wire logic output_invert_enable,
    input wire logic pwm_timer_waveform,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_n
);
    import rtp_pkg::*;

    if (PINS < 1)
    begin : g_bad_pins
        $error("pin_drive: PINS must be at least 1");
    end

    for (genvar n = 0; n < PINS; n++)
    begin : g_pin
        logic rt_active;
        logic raw;
        logic level;

        // R3 R2 real-time selection
        assign rt_active = rt_output_enable & per_pin_rt_select[n];
        // R6 PWM replaces level
        assign raw = (modulation_dc_enable & pwm_enable[n]) ?
                     (rt_latch[n] & pwm_timer_waveform) : rt_latch[n];
        // R4 inversion on real-time pins
        // R5 set latch drives high
        assign level = pin_output_latch[n] |
                       (rt_active & (raw ^ output_invert_enable));

        // R5 direction overrides all
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
            begin
                pin_out[n] <= 1'b0;
                pin_oe_n[n] <= 1'b1;
            end
            else
            begin
                pin_out[n] <= pin_direction_bit[n] ? 1'b0 : level;
                pin_oe_n[n] <= pin_direction_bit[n];
            end
        end
    end
endmodule
`default_nettype wire

/* design/realtime_pattern_output_port.sv */
// Real-time pattern output port with Avalon-MM register access.
// Assumes the interval timer interrupt and PWM waveform come from logic
// on sys_clk; the external trigger and port pins are asynchronous.
//
// Overview of operation
// R1: Preloaded 8-bit pattern buffer, one 8-bit or two 4-bit channels.
// R2: Per-pin select chooses real-time buffer path or ordinary port output. The ordinary port latch is ORed onto real-time pins too.
// R3: Port control selects mode and holds enable; clear enable stops output.
// R4: Modulation control holds PWM enable and inversion enable.
// R5: Direction bit 1 makes pin input; else high, low or PWM output.
// R6: With PWM on and buffer bit set, pin carries timer waveform.
// R7: 8-bit inverted PWM: clear external select, set byte, invert, both PWM.
// R8: Software rewrites both buffer halves in the interval timer handler.
// R9: Hardware copies buffer to output latch on timer or external trigger.
// R10: In 4-bit mode each nibble moves only on its own trigger.
`timescale 1ns/1ps
`default_nettype none
module realtime_pattern_output_port #(
    parameter int PINS = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [rtp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [rtp_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [rtp_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic interval_timer_interrupt,
    input wire logic ext_trigger_pin,
    input wire logic pwm_timer_waveform,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_n
);
    import rtp_pkg::*;

    // The transfer logic splits the port into exactly two nibbles.
    if (PINS != PORT_W || 2 * NIB_W != PORT_W)
    begin : g_bad_width
        $error("realtime_pattern_output_port: PINS must equal 8");
    end

    typedef enum {BUS_IDLE, BUS_ANSWER} bus_state_t;

    // Software-visible registers.
    logic [NIB_W-1:0] pattern_buffer_upper_q;
    logic [NIB_W-1:0] pattern_buffer_lower_q;
    logic [PORT_W-1:0] per_pin_rt_select_q;
    logic [PC_W-1:0] rt_port_control_q;
    logic [MC_W-1:0] modulation_control_q;
    logic [PORT_W-1:0] pin_output_latch_q;
    logic [PORT_W-1:0] pin_direction_bit_q;
    logic [PORT_W-1:0] rt_latch_q;
    // Bus handshake state.
    bus_state_t bus_state_q;
    bus_state_t bus_state_d;
    logic answer_phase;
    logic rd_take;
    logic ext_trig_prev_q;
    logic [DATA_W-1:0] rdata_d;
    logic [PORT_W-1:0] pin_level;
    logic ext_trig_level;
    logic ext_trig_pulse;
    logic wr_en;
    logic wr_buf_upper;
    logic wr_buf_lower;
    logic wr_pin_select;
    logic wr_port_ctrl;
    logic wr_mod_ctrl;
    logic wr_port_latch;
    logic wr_pin_dir;
    logic take_lower;
    logic take_upper;
    logic byte_width_select;
    logic external_trigger_select;
    logic rt_output_enable;
    logic [PORT_W-1:0] pwm_enable;

    // Transfer path.
    logic [PORT_W-1:0] pattern_buffer;
    logic [1:0] take_nib;

    assign byte_width_select = rt_port_control_q[PC_BYTE_BIT];
    assign external_trigger_select = rt_port_control_q[PC_EXTR_BIT];
    assign rt_output_enable = rt_port_control_q[PC_OE_BIT];
    // Each nibble has its own PWM enable; a pin takes that of its nibble.
    assign pwm_enable = {{NIB_W{modulation_control_q[MC_PWMH_BIT]}},
                         {NIB_W{modulation_control_q[MC_PWML_BIT]}}};

    // External trigger and pin readback are asynchronous to sys_clk.
    pin_sync #(
        .WIDTH(1)
    ) u_trig_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(ext_trigger_pin),
        .sync_out(ext_trig_level)
    );

    pin_sync #(
        .WIDTH(PORT_W)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_level)
    );

    // The trigger pin idles low and the edge history resets low, so a
    // release from reset never looks like a trigger.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            ext_trig_prev_q <= 1'b0;
        else
            ext_trig_prev_q <= ext_trig_level;
    end

    assign ext_trig_pulse = ext_trig_level & ~ext_trig_prev_q;

    // Bus access completes on the second edge of every request: the
    // request edge does the work, the answer edge lets the master go.
    assign answer_phase = (bus_state_q == BUS_ANSWER);
    assign avs_waitrequest = (avs_read | avs_write) & ~answer_phase;
    assign rd_take = avs_read & ~answer_phase;
    assign wr_en = avs_write & ~answer_phase & avs_byteenable[0];

    // A request is taken in the idle state; the answer state lasts one
    // cycle so that a held request is never taken twice.
    always_comb
    begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            BUS_IDLE:
                if (avs_read || avs_write)
                    bus_state_d = BUS_ANSWER;
            BUS_ANSWER:
                bus_state_d = BUS_IDLE;
            default:
                bus_state_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            bus_state_q <= BUS_IDLE;
        else
            bus_state_q <= bus_state_d;
    end

    // One write strobe per register; unmapped offsets and the read-only
    // real-time latch select none of them.
    assign wr_buf_upper = wr_en && (avs_address == OFS_BUF_UPPER);
    assign wr_buf_lower = wr_en && (avs_address == OFS_BUF_LOWER);
    assign wr_pin_select = wr_en && (avs_address == OFS_PIN_SELECT);
    assign wr_port_ctrl = wr_en && (avs_address == OFS_PORT_CTRL);
    assign wr_mod_ctrl = wr_en && (avs_address == OFS_MOD_CTRL);
    assign wr_port_latch = wr_en && (avs_address == OFS_PORT_LATCH);
    assign wr_pin_dir = wr_en && (avs_address == OFS_PIN_DIR);

    // R1 pattern buffer halves
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pattern_buffer_upper_q <= RST_NIB;
            pattern_buffer_lower_q <= RST_NIB;
        end
        else if (wr_buf_upper)
            pattern_buffer_upper_q <= avs_writedata[NIB_W-1:0];
        else if (wr_buf_lower)
            pattern_buffer_lower_q <= avs_writedata[NIB_W-1:0];
    end

    // R2 per-pin select
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            per_pin_rt_select_q <= RST_SELECT;
        else if (wr_pin_select)
            per_pin_rt_select_q <= avs_writedata[PORT_W-1:0];
    end

    // R3 port control
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rt_port_control_q <= RST_PC;
        else if (wr_port_ctrl)
            rt_port_control_q <= avs_writedata[PC_W-1:0];
    end

    // R4 modulation control
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            modulation_control_q <= RST_MC;
        else if (wr_mod_ctrl)
            modulation_control_q <= avs_writedata[MC_W-1:0];
    end

    // Ordinary port latch, ORed onto every pin whether in real-time mode or not.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pin_output_latch_q <= RST_LATCH;
        else if (wr_port_latch)
            pin_output_latch_q <= avs_writedata[PORT_W-1:0];
    end

    // R5 direction register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pin_direction_bit_q <= RST_DIR;
        else if (wr_pin_dir)
            pin_direction_bit_q <= avs_writedata[PORT_W-1:0];
    end

    // In byte mode the selected source moves the whole pattern. In nibble
    // mode the interval timer owns the lower half and the external trigger
    // the upper half.
    always_comb
    begin
        if (byte_width_select)
        begin
            take_lower = external_trigger_select ? ext_trig_pulse
                                                 : interval_timer_interrupt;
            take_upper = take_lower;
        end
        else
        begin
            take_lower = interval_timer_interrupt;
            take_upper = ext_trig_pulse;
        end
    end

    // Channel 0 is the lower nibble, channel 1 the upper nibble.
    assign pattern_buffer = {pattern_buffer_upper_q, pattern_buffer_lower_q};
    assign take_nib = {take_upper, take_lower};

    // Each channel keeps its nibble until its own trigger, so software may
    // rewrite the buffer at any time between two triggers.
    // R9 hardware transfer
    for (genvar c = 0; c < PORT_W / NIB_W; c++)
    begin : g_chan
        // R10 independent nibble transfer
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                rt_latch_q[c*NIB_W +: NIB_W] <= RST_LATCH[c*NIB_W +: NIB_W];
            else if (take_nib[c])
                rt_latch_q[c*NIB_W +: NIB_W] <=
                    pattern_buffer[c*NIB_W +: NIB_W];
        end
    end

    // Read data is chosen on the request edge and stands with the answer.
    always_comb
    begin
        rdata_d = '0;
        case (avs_address)
            OFS_BUF_UPPER: rdata_d[NIB_W-1:0] = pattern_buffer_upper_q;
            OFS_BUF_LOWER: rdata_d[NIB_W-1:0] = pattern_buffer_lower_q;
            OFS_PIN_SELECT: rdata_d[PORT_W-1:0] = per_pin_rt_select_q;
            OFS_PORT_CTRL: rdata_d[PC_W-1:0] = rt_port_control_q;
            OFS_MOD_CTRL: rdata_d[MC_W-1:0] = modulation_control_q;
            OFS_PORT_LATCH: rdata_d[PORT_W-1:0] = pin_level;
            OFS_PIN_DIR: rdata_d[PORT_W-1:0] = pin_direction_bit_q;
            OFS_RT_LATCH: rdata_d[PORT_W-1:0] = rt_latch_q;
            default: rdata_d = '0;
        endcase
    end

    // Read data is loaded only on the request edge, so it stands until
    // the next read is taken.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            avs_readdata <= '0;
        else if (rd_take)
            avs_readdata <= rdata_d;
    end

    // R6 R7 output waveform selection
    pin_drive #(
        .PINS(PORT_W)
    ) u_pin_drive (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_direction_bit(pin_direction_bit_q),
        .pin_output_latch(pin_output_latch_q),
        .rt_latch(rt_latch_q),
        .per_pin_rt_select(per_pin_rt_select_q),
        .pwm_enable(pwm_enable),
        .rt_output_enable(rt_output_enable),
        .modulation_dc_enable(modulation_control_q[MC_DCEN_BIT]),
        .output_invert_enable(modulation_control_q[MC_INV_BIT]),
        .pwm_timer_waveform(pwm_timer_waveform),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n)
    );
endmodule
`default_nettype wire

/* sim/far_side_model.sv */
// Far-side model: the pin wiring towards the driver transistors.
// Assumes released pins are held high by pull-ups on the board.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    output logic [7:0] pin_level
);
    assign pin_level = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule
`default_nettype wire

/* sim/realtime_pattern_output_port_sva.sv */
// Checker for the port's bus handshake and pin outputs.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module rtp_checker #(
    parameter int PINS = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [rtp_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic interval_timer_interrupt,
    input wire logic ext_trigger_pin,
    input wire logic pwm_timer_waveform,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wait_once_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer took more than one wait cycle");
    idle_ready_a: assert property (
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high without a request");
    pin_off_a: assert property ((pin_out & pin_oe_n) == '0)
        else $error("released pin carries a high level");
    reset_pins_a: assert property (
        $fell(rst) |-> pin_oe_n == '1 && pin_out == '0)
        else $error("pins not released by reset");
    read_upper_a: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == '0)
        else $error("read data upper bits not zero");
    data_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    oe_hold_a: assert property (!avs_write [*3] |=> $stable(pin_oe_n))
        else $error("pin direction changed without a write");
    out_hold_a: assert property (
        (!avs_write && !interval_timer_interrupt && !ext_trigger_pin &&
        !pwm_timer_waveform) [*7] |-> $stable(pin_out))
        else $error("pin level changed without a cause");
endmodule
bind realtime_pattern_output_port rtp_checker #(.PINS(PINS)) chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .interval_timer_interrupt(interval_timer_interrupt),
    .ext_trigger_pin(ext_trigger_pin),
    .pwm_timer_waveform(pwm_timer_waveform),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
);
`default_nettype wire

/* sim/realtime_pattern_output_port_bench.sv */
// Self-checking bench for the real-time pattern output port.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module realtime_pattern_output_port_bench;
    import rtp_pkg::*;
    logic sys_clk = 0, rst = 1, rd = 0, wr = 0, tick = 0, ext = 0, pwm = 0;
    logic [4:0] adr = 0;
    logic [3:0] be = 4'hf;
    logic [31:0] wd = 0, q;
    logic wq;
    logic [7:0] pout, poe, lvl, r;
    int n_errors = 0, compares = 0;
    realtime_pattern_output_port #(.PINS(8)) uut (.sys_clk(sys_clk),
        .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(q),
        .avs_waitrequest(wq), .interval_timer_interrupt(tick),
        .ext_trigger_pin(ext), .pwm_timer_waveform(pwm), .pin_in(lvl),
        .pin_out(pout), .pin_oe_n(poe));
    far_side_model fm (.pin_out(pout), .pin_oe_n(poe), .pin_level(lvl));
    initial forever #20 sys_clk = ~sys_clk;
    task automatic bus(input logic w, logic [4:0] a, logic [7:0] d);
        @(posedge sys_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {24'h0, d};
        @(posedge sys_clk);
        while (wq !== 1'b0) @(posedge sys_clk);
        r = q[7:0];
        rd <= 0;
        wr <= 0;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e, string n);
        bus(0, a, 8'h00);
        `CHK(n, e, r)
    endtask
    task automatic pchk(input logic [7:0] e);
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK("pin_out", e, pout)
    endtask
    // Raises the interval pulse or holds the external pin high.
    task automatic trig(input logic e);
        @(posedge sys_clk);
        tick <= !e;
        ext <= e;
        @(posedge sys_clk);
        tick <= 0;
        repeat (6) @(posedge sys_clk);
        ext <= 0;
    endtask
    task automatic t_reset;
        pchk(8'h00);
        `CHK("pin_oe_n", 8'hff, poe)
        rchk(OFS_PIN_SELECT, RST_SELECT, "select");
        be <= 4'he;
        bus(1, OFS_PIN_SELECT, 8'h3c);
        be <= 4'hf;
        rchk(OFS_PIN_SELECT, RST_SELECT, "select_be");
        rchk(OFS_PORT_CTRL, 8'h00, "port_ctrl");
        rchk(OFS_MOD_CTRL, 8'h00, "mod_ctrl");
        rchk(OFS_PIN_DIR, RST_DIR, "direction");
        bus(1, OFS_RT_LATCH, 8'h5a);
        rchk(OFS_RT_LATCH, 8'h00, "rt_latch");
        rchk(5'h02, 8'h00, "unmapped");
    endtask
    task automatic t_byte;
        bus(1, OFS_BUF_UPPER, 8'h0a);
        bus(1, OFS_BUF_LOWER, 8'h05);
        bus(1, OFS_PIN_SELECT, 8'hff);
        bus(1, OFS_PIN_DIR, 8'h00);
        bus(1, OFS_PORT_CTRL, 8'h05);
        pchk(8'h00);
        trig(0);
        pchk(8'ha5);
        `CHK("pin_oe_n", 8'h00, poe)
        rchk(OFS_RT_LATCH, 8'ha5, "rt_latch");
        rchk(OFS_PORT_LATCH, 8'ha5, "pin_in");
    endtask
    task automatic t_nibble;
        bus(1, OFS_PORT_CTRL, 8'h04);
        bus(1, OFS_BUF_UPPER, 8'h03);
        bus(1, OFS_BUF_LOWER, 8'h0c);
        trig(0);
        pchk(8'hac);
        trig(1);
        pchk(8'h3c);
    endtask
    task automatic t_extsel;
        bus(1, OFS_PORT_CTRL, 8'h07);
        bus(1, OFS_BUF_UPPER, 8'h09);
        bus(1, OFS_BUF_LOWER, 8'h06);
        trig(0);
        pchk(8'h3c);
        trig(1);
        pchk(8'h96);
    endtask
    task automatic t_mod;
        bus(1, OFS_PORT_CTRL, 8'h05);
        bus(1, OFS_MOD_CTRL, 8'h0f);
        pwm <= 1;
        pchk(8'h69);
        pwm <= 0;
        pchk(8'hff);
        bus(1, OFS_MOD_CTRL, 8'h02);
        pchk(8'h69);
        bus(1, OFS_MOD_CTRL, 8'h00);
        pchk(8'h96);
    endtask
    task automatic t_port;
        bus(1, OFS_PORT_LATCH, 8'h2f);
        bus(1, OFS_PIN_SELECT, 8'hf0);
        pchk(8'hbf);
        bus(1, OFS_PORT_CTRL, 8'h01);
        pchk(8'h2f);
        bus(1, OFS_PIN_DIR, 8'h0f);
        pchk(8'h20);
        `CHK("pin_oe_n", 8'h0f, poe)
        rchk(OFS_PORT_LATCH, 8'h2f, "pin_in");
    endtask
    task automatic complete_run;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        t_reset();
        t_byte();
        t_nibble();
        t_extsel();
        t_mod();
        t_port();
        complete_run();
    end
    initial
    begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
